// ===== logic/caf_core.sv
`timescale 1ns/1ps

module caf_core
  import caf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        req_valid,
  input  wire caf_req_t    req,
  input  wire logic        exc_entry,
  input  wire logic        irq_pin,
  input  wire logic        nmi_pin,
  input  wire logic [15:0] fetch_pc,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             ready_q,
  output logic             done_q,
  output logic             illegal_q,
  output logic [31:0]      result_q,
  output logic [7:0]       flags_q,
  output logic             maskable_accept_q,
  output logic             nmi_accept_q,
  output logic [15:0]      fetch_addr_q,
  output logic             mem_req_q,
  output logic             mem_we_q,
  output caf_size_t        mem_size_q,
  output logic [15:0]      mem_addr_q,
  output logic [31:0]      mem_wdata_q
);

  logic [31:0] regs_q [CAF_NUM_REGS];
  caf_state_t  state_q;
  caf_req_t    pend_q;
  logic [31:0] pend_sp_q;
  logic [1:0]  irq_sync_q;
  logic [1:0]  nmi_sync_q;

  logic        take;
  logic [31:0] ra, rb, a, b, x, y, res, sp_next, mem_addr, amount;
  logic [32:0] wide;
  logic [15:0] prod16;
  logic [31:0] prod32;
  caf_size_t   res_size;
  caf_fk_t     fk;
  logic        res_we, illegal, is_mem, flag_op, cin;
  logic [7:0]  flag_val;
  logic        wr_en, sp_en, flags_we;
  logic [3:0]  wr_idx;
  caf_size_t   wr_size;
  logic [31:0] wr_val;
  logic [7:0]  flags_d;

  // register view at a given size; low-half bytes only
  function automatic logic [31:0] read_op(input logic [31:0] r,
                                          input logic hi,
                                          input caf_size_t s);
    unique case (s)
      CAF_BYTE: read_op = {24'h0, hi ? r[7:0] : r[15:8]};
      CAF_WORD: read_op = {16'h0, hi ? r[31:16] : r[15:0]};
      default:  read_op = r;
    endcase
  endfunction

  // merge a sized value back into its register
  function automatic logic [31:0] put_op(input logic [31:0] r,
                                         input logic hi,
                                         input caf_size_t s,
                                         input logic [31:0] v);
    put_op = r;
    unique case (s)
      CAF_BYTE:
        if (hi) put_op[7:0] = v[7:0];
        else put_op[15:8] = v[7:0];
      CAF_WORD:
        if (hi) put_op[31:16] = v[15:0];
        else put_op[15:0] = v[15:0];
      default: put_op = v;
    endcase
  endfunction

  function automatic logic [31:0] size_mask(input logic [31:0] v,
                                            input caf_size_t s);
    unique case (s)
      CAF_BYTE: size_mask = {24'h0, v[7:0]};
      CAF_WORD: size_mask = {16'h0, v[15:0]};
      default:  size_mask = v;
    endcase
  endfunction

  function automatic logic msb_of(input logic [31:0] v,
                                  input caf_size_t s);
    unique case (s)
      CAF_BYTE: msb_of = v[7];
      CAF_WORD: msb_of = v[15];
      default:  msb_of = v[31];
    endcase
  endfunction

  // carry out of the top bit at operand size
  function automatic logic carry_of(input logic [32:0] v,
                                    input caf_size_t s);
    unique case (s)
      CAF_BYTE: carry_of = v[8];
      CAF_WORD: carry_of = v[16];
      default:  carry_of = v[32];
    endcase
  endfunction

  // carry into the bit above the half-carry source
  function automatic logic half_of(input logic [31:0] v,
                                   input caf_size_t s);
    unique case (s)
      CAF_BYTE: half_of = v[CAF_HALF_BYTE+1];
      CAF_WORD: half_of = v[CAF_HALF_WORD+1];
      default:  half_of = v[CAF_HALF_LONG+1];
    endcase
  endfunction

  // word and longword accesses never see an odd address
  function automatic logic [15:0] align(input logic [15:0] ad,
                                        input caf_size_t s);
    align = (s == CAF_BYTE) ? ad : {ad[15:1], 1'b0};
  endfunction

  assign take = req_valid && ready_q;

  // operation decode and datapath
  always_comb
  begin
    ra       = regs_q[req.dst[2:0]];
    rb       = regs_q[req.src[2:0]];
    a        = read_op(ra, req.dst[3], req.size);
    b        = req.use_imm ? size_mask(req.imm, req.size)
                           : read_op(rb, req.src[3], req.size);
    x        = a;
    y        = b;
    wide     = {1'b0, a};
    res      = a;
    res_size = req.size;
    res_we   = 1'b1;
    fk       = CAF_FK_NONE;
    illegal  = 1'b0;
    is_mem   = 1'b0;
    flag_op  = 1'b0;
    flag_val = flags_q;
    cin      = 1'b0;
    prod16   = '0;
    prod32   = '0;
    mem_addr = '0;
    sp_next  = regs_q[CAF_STACK_POINTER_REGISTER];
    amount   = (req.size != CAF_BYTE && req.imm[1]) ? CAF_STEP_TWO
                                                   : CAF_STEP_ONE;
    unique case (req.op)
      CAF_MOVE:
      begin
        res = b;
        fk  = CAF_FK_LOGIC;
      end
      CAF_ADD, CAF_SUM_WITH_CARRY:
      begin
        cin     = (req.op == CAF_SUM_WITH_CARRY) && flags_q[CAF_FLAG_C];
        illegal = (req.op == CAF_SUM_WITH_CARRY) && req.size != CAF_BYTE;
        fk      = CAF_FK_ADD;
      end
      CAF_SUB, CAF_DIFFERENCE_WITH_BORROW, CAF_COMPARE_OP, CAF_NEGATE:
      begin
        cin     = (req.op == CAF_DIFFERENCE_WITH_BORROW)
                  && flags_q[CAF_FLAG_C];
        illegal = (req.op == CAF_SUB && req.use_imm
                   && req.size == CAF_BYTE)
                  || (req.op == CAF_DIFFERENCE_WITH_BORROW
                      && req.size != CAF_BYTE);
        res_we  = (req.op != CAF_COMPARE_OP);
        if (req.op == CAF_NEGATE)
        begin
          x = '0;
          y = a;
        end
        fk = CAF_FK_SUB;
      end
      CAF_STEP_UP, CAF_STEP_DOWN:
      begin
        y  = amount;
        fk = (req.op == CAF_STEP_UP) ? CAF_FK_STEP_ADD : CAF_FK_STEP_SUB;
      end
      CAF_POINTER_INCREMENT, CAF_POINTER_DECREMENT:
      begin
        amount  = req.imm[2] ? CAF_STEP_FOUR :
                  req.imm[1] ? CAF_STEP_TWO : CAF_STEP_ONE;
        illegal = (req.size != CAF_LONG);
        res     = (req.op == CAF_POINTER_INCREMENT) ? a + amount
                                                   : a - amount;
      end
      CAF_DECIMAL_FIX_AFTER_SUM, CAF_DECIMAL_FIX_AFTER_DIFF:
      begin
        illegal = (req.size != CAF_BYTE);
        fk      = CAF_FK_LOGIC;
        // digit fixes depend on the flags left by the previous add/sub
        if (req.op == CAF_DECIMAL_FIX_AFTER_SUM)
        begin
          flag_val[CAF_FLAG_C] = flags_q[CAF_FLAG_C]
                                 || a[7:0] > CAF_BCD_BYTE_MAX;
          res[7:0] = a[7:0]
            + ((flags_q[CAF_FLAG_H] || a[3:0] > CAF_BCD_DIGIT_MAX)
               ? CAF_BCD_LOW_FIX : 8'h00)
            + (flag_val[CAF_FLAG_C] ? CAF_BCD_HIGH_FIX : 8'h00);
        end
        else
          res[7:0] = a[7:0]
            - (flags_q[CAF_FLAG_H] ? CAF_BCD_LOW_FIX : 8'h00)
            - (flags_q[CAF_FLAG_C] ? CAF_BCD_HIGH_FIX : 8'h00);
      end
      CAF_UNSIGNED_MULTIPLY, CAF_SIGNED_MULTIPLY:
      begin
        illegal = (req.size == CAF_LONG);
        x = read_op(ra, req.dst[3], CAF_WORD);
        if (req.size == CAF_BYTE)
        begin
          res_size = CAF_WORD;
          prod16 = (req.op == CAF_SIGNED_MULTIPLY)
            ? 16'($signed({{8{x[7]}}, x[7:0]})
                  * $signed({{8{b[7]}}, b[7:0]}))
            : {8'h00, x[7:0]} * {8'h00, b[7:0]};
          res = {16'h0, prod16};
        end
        else
        begin
          res_size = CAF_LONG;
          prod32 = (req.op == CAF_SIGNED_MULTIPLY)
            ? 32'($signed({{16{x[15]}}, x[15:0]})
                  * $signed({{16{b[15]}}, b[15:0]}))
            : {16'h0, x[15:0]} * {16'h0, b[15:0]};
          res = prod32;
        end
        if (req.op == CAF_SIGNED_MULTIPLY)
        begin
          flag_val[CAF_FLAG_N] = msb_of(res, res_size);
          flag_val[CAF_FLAG_Z] = (res == '0);
        end
      end
      CAF_UNSIGNED_DIVIDE, CAF_SIGNED_DIVIDE:
      begin
        illegal  = (req.size == CAF_LONG);
        res_size = (req.size == CAF_BYTE) ? CAF_WORD : CAF_LONG;
        x = read_op(ra, req.dst[3], res_size);
        // a zero divisor leaves the dividend in place
        res_we = (b != '0);
        if (req.size == CAF_BYTE && req.op == CAF_UNSIGNED_DIVIDE
            && res_we)
          res = {16'h0, 8'(x[15:0] % {8'h00, b[7:0]}),
                 8'(x[15:0] / {8'h00, b[7:0]})};
        else if (req.size == CAF_BYTE && res_we)
          res = {16'h0,
                 8'($signed(x[15:0]) % $signed({{8{b[7]}}, b[7:0]})),
                 8'($signed(x[15:0]) / $signed({{8{b[7]}}, b[7:0]}))};
        else if (req.op == CAF_UNSIGNED_DIVIDE && res_we)
          res = {16'(x % {16'h0, b[15:0]}),
                 16'(x / {16'h0, b[15:0]})};
        else if (res_we)
          res = {16'($signed(x) % $signed({{16{b[15]}}, b[15:0]})),
                 16'($signed(x) / $signed({{16{b[15]}}, b[15:0]}))};
        flag_val[CAF_FLAG_N] = (req.op == CAF_SIGNED_DIVIDE)
          ? msb_of(res, req.size) : msb_of(b, req.size);
        flag_val[CAF_FLAG_Z] = (b == '0);
      end
      CAF_ZERO_WIDEN, CAF_SIGN_WIDEN:
      begin
        illegal = (req.size == CAF_BYTE);
        fk      = CAF_FK_LOGIC;
        if (req.size == CAF_WORD)
          res = {16'h0, (req.op == CAF_SIGN_WIDEN) ? {8{a[7]}} : 8'h00,
                 a[7:0]};
        else
          res = {(req.op == CAF_SIGN_WIDEN) ? {16{a[15]}} : 16'h0,
                 a[15:0]};
      end
      CAF_AND, CAF_OR, CAF_XOR, CAF_INVERT:
      begin
        fk  = CAF_FK_LOGIC;
        res = (req.op == CAF_AND) ? a & b :
              (req.op == CAF_OR)  ? a | b :
              (req.op == CAF_XOR) ? a ^ b :
              size_mask(~a, req.size);
      end
      CAF_LOAD_FLAGS_INSN, CAF_FLAGS_MASK_INSN, CAF_FLAGS_SET_INSN,
      CAF_FLAGS_TOGGLE_INSN:
      begin
        // the only path that reaches the user bits
        res_we   = 1'b0;
        flag_op  = 1'b1;
        b        = req.use_imm ? req.imm
                               : read_op(rb, req.src[3], CAF_BYTE);
        flag_val = (req.op == CAF_LOAD_FLAGS_INSN) ? b[7:0] :
                   (req.op == CAF_FLAGS_MASK_INSN) ? flags_q & b[7:0] :
                   (req.op == CAF_FLAGS_SET_INSN)  ? flags_q | b[7:0] :
                   flags_q ^ b[7:0];
      end
      CAF_STORE_FLAGS_INSN:
      begin
        res_size = CAF_BYTE;
        res      = {24'h0, flags_q};
      end
      CAF_MEM_LOAD, CAF_MEM_STORE:
      begin
        is_mem   = 1'b1;
        mem_addr = (req.op == CAF_MEM_LOAD) ? rb : ra;
        res      = b;
      end
      CAF_PUSH, CAF_POP:
      begin
        is_mem  = 1'b1;
        illegal = (req.size == CAF_BYTE);
        amount  = (req.size == CAF_LONG) ? CAF_STEP_FOUR : CAF_STEP_TWO;
        res     = a;
        // push: address is the decremented pointer
        sp_next = (req.op == CAF_PUSH)
          ? regs_q[CAF_STACK_POINTER_REGISTER] - amount
          : regs_q[CAF_STACK_POINTER_REGISTER] + amount;
        mem_addr = (req.op == CAF_PUSH) ? sp_next
                   : regs_q[CAF_STACK_POINTER_REGISTER];
      end
    endcase

    // shared adder for add, subtract and step families
    if (fk == CAF_FK_ADD || fk == CAF_FK_STEP_ADD)
      wide = {1'b0, x} + {1'b0, y} + {32'h0, cin};
    else if (fk == CAF_FK_SUB || fk == CAF_FK_STEP_SUB)
      wide = {1'b0, x} - {1'b0, y} - {32'h0, cin};
    if (fk != CAF_FK_NONE && fk != CAF_FK_LOGIC)
      res = size_mask(wide[31:0], res_size);
    if (fk != CAF_FK_NONE)
    begin
      flag_val[CAF_FLAG_N] = msb_of(res, res_size);
      flag_val[CAF_FLAG_Z] = (size_mask(res, res_size) == '0);
      flag_val[CAF_FLAG_V] = 1'b0;
    end
    if (fk == CAF_FK_ADD || fk == CAF_FK_STEP_ADD)
      flag_val[CAF_FLAG_V] = (msb_of(x, res_size) == msb_of(y, res_size))
        && (msb_of(res, res_size) != msb_of(x, res_size));
    if (fk == CAF_FK_SUB || fk == CAF_FK_STEP_SUB)
      flag_val[CAF_FLAG_V] = (msb_of(x, res_size) != msb_of(y, res_size))
        && (msb_of(res, res_size) != msb_of(x, res_size));
    if (fk == CAF_FK_ADD || fk == CAF_FK_SUB)
    begin
      flag_val[CAF_FLAG_H] = half_of(x ^ y ^ res, res_size);
      flag_val[CAF_FLAG_C] = carry_of(wide, res_size);
    end
    // user bits are held against every other operation
    if (!flag_op)
    begin
      flag_val[CAF_FLAG_USER_UPPER] = flags_q[CAF_FLAG_USER_UPPER];
      flag_val[CAF_FLAG_USER_LOWER] = flags_q[CAF_FLAG_USER_LOWER];
      flag_val[CAF_FLAG_I]          = flags_q[CAF_FLAG_I];
    end
  end

  // write-back steering for register file and flags
  always_comb
  begin
    wr_en    = 1'b0;
    sp_en    = 1'b0;
    flags_we = 1'b0;
    wr_idx   = req.dst;
    wr_size  = res_size;
    wr_val   = res;
    flags_d  = flag_val;
    if (take && !illegal && !is_mem)
    begin
      wr_en    = res_we;
      flags_we = 1'b1;
    end
    if (state_q == CAF_MEM && mem_ack)
    begin
      wr_idx  = pend_q.dst;
      wr_size = pend_q.size;
      wr_val  = size_mask(mem_rdata, pend_q.size);
      wr_en   = (pend_q.op == CAF_MEM_LOAD || pend_q.op == CAF_POP);
      sp_en   = (pend_q.op == CAF_PUSH || pend_q.op == CAF_POP);
      // transfers set N and Z from the data moved, clear V
      flags_we = 1'b1;
      flags_d  = flags_q;
      flags_d[CAF_FLAG_N] = msb_of(wr_en ? wr_val : pend_q.imm,
                                   pend_q.size);
      flags_d[CAF_FLAG_Z] = ((wr_en ? wr_val : pend_q.imm) == '0);
      flags_d[CAF_FLAG_V] = 1'b0;
    end
  end

  // general registers; a pop into the stack pointer keeps the data
  for (genvar j = 0; j < CAF_NUM_REGS; j++)
  begin : g_reg
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        regs_q[j] <= '0;
      else if (clk_en)
      begin
        if (wr_en && wr_idx[2:0] == 3'(j))
          regs_q[j] <= put_op(regs_q[j], wr_idx[3], wr_size, wr_val);
        else if (sp_en && 3'(j) == CAF_STACK_POINTER_REGISTER)
          regs_q[j] <= pend_sp_q;
      end
    end
  end

  // condition flags; exception entry wins over a same-cycle write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_q <= CAF_FLAGS_RESET;
    else if (clk_en)
    begin
      if (flags_we)
        flags_q <= flags_d;
      if (exc_entry)
        flags_q[CAF_FLAG_I] <= 1'b1;
    end
  end

  // request sequencing and memory handshake
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= CAF_IDLE;
      ready_q     <= 1'b1;
      done_q      <= 1'b0;
      illegal_q   <= 1'b0;
      result_q    <= '0;
      pend_q      <= '0;
      pend_sp_q   <= '0;
      mem_req_q   <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_size_q  <= CAF_BYTE;
      mem_addr_q  <= '0;
      mem_wdata_q <= '0;
    end
    else if (clk_en)
    begin
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
      unique case (state_q)
        CAF_IDLE:
          if (take && is_mem && !illegal)
          begin
            state_q     <= CAF_MEM;
            ready_q     <= 1'b0;
            pend_q      <= req;
            pend_q.imm  <= res;
            pend_sp_q   <= sp_next;
            mem_req_q   <= 1'b1;
            mem_we_q    <= (req.op == CAF_MEM_STORE || req.op == CAF_PUSH);
            mem_size_q  <= req.size;
            mem_addr_q  <= align(mem_addr[15:0], req.size);
            mem_wdata_q <= res;
          end
          else if (take)
          begin
            done_q    <= 1'b1;
            illegal_q <= illegal;
            result_q  <= illegal ? result_q : res;
          end
        CAF_MEM:
          if (mem_ack)
          begin
            state_q   <= CAF_IDLE;
            ready_q   <= 1'b1;
            mem_req_q <= 1'b0;
            mem_we_q  <= 1'b0;
            done_q    <= 1'b1;
            result_q  <= wr_en ? wr_val : pend_q.imm;
          end
      endcase
    end
  end

  // pin synchronisers, then maskable acceptance against the mask; NMI acceptance ignores it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_sync_q        <= '0;
      nmi_sync_q        <= '0;
      maskable_accept_q <= 1'b0;
      nmi_accept_q      <= 1'b0;
      fetch_addr_q      <= '0;
    end
    else if (clk_en)
    begin
      irq_sync_q        <= {irq_sync_q[0], irq_pin};
      nmi_sync_q        <= {nmi_sync_q[0], nmi_pin};
      maskable_accept_q <= irq_sync_q[1] && !flags_q[CAF_FLAG_I];
      nmi_accept_q      <= nmi_sync_q[1];
      fetch_addr_q      <= align(fetch_pc, CAF_WORD);
    end
  end

endmodule

// ===== logic/caf_pkg.sv
package caf_pkg;

  // operand sizes; the fourth code is never issued
  typedef enum logic [1:0] {CAF_BYTE, CAF_WORD, CAF_LONG} caf_size_t;

  // operations carried out by the datapath, one request each
  typedef enum logic [4:0] {
    CAF_MOVE, CAF_ADD, CAF_SUM_WITH_CARRY, CAF_SUB,
    CAF_DIFFERENCE_WITH_BORROW, CAF_STEP_UP, CAF_STEP_DOWN,
    CAF_POINTER_INCREMENT, CAF_POINTER_DECREMENT,
    CAF_DECIMAL_FIX_AFTER_SUM, CAF_DECIMAL_FIX_AFTER_DIFF,
    CAF_UNSIGNED_MULTIPLY, CAF_SIGNED_MULTIPLY, CAF_UNSIGNED_DIVIDE,
    CAF_SIGNED_DIVIDE, CAF_COMPARE_OP, CAF_NEGATE, CAF_ZERO_WIDEN,
    CAF_SIGN_WIDEN, CAF_AND, CAF_OR, CAF_XOR, CAF_INVERT,
    CAF_LOAD_FLAGS_INSN, CAF_STORE_FLAGS_INSN, CAF_FLAGS_MASK_INSN,
    CAF_FLAGS_SET_INSN, CAF_FLAGS_TOGGLE_INSN, CAF_MEM_LOAD,
    CAF_MEM_STORE, CAF_PUSH, CAF_POP
  } caf_op_t;

  // how an operation touches the arithmetic flags
  typedef enum logic [2:0] {
    CAF_FK_NONE, CAF_FK_ADD, CAF_FK_SUB, CAF_FK_STEP_ADD,
    CAF_FK_STEP_SUB, CAF_FK_LOGIC
  } caf_fk_t;

  typedef enum logic {CAF_IDLE, CAF_MEM} caf_state_t;

  // one operation request
  typedef struct packed {
    caf_op_t     op;
    caf_size_t   size;
    logic [3:0]  dst;
    logic [3:0]  src;
    logic        use_imm;
    logic [31:0] imm;
  } caf_req_t;

  localparam int         CAF_NUM_REGS      = 8;
  localparam logic [2:0] CAF_STACK_POINTER_REGISTER = 3'h7;

  // condition flag bit positions and reset value
  localparam int         CAF_FLAG_I        = 7;
  localparam int         CAF_FLAG_USER_UPPER = 6;
  localparam int         CAF_FLAG_H        = 5;
  localparam int         CAF_FLAG_USER_LOWER = 4;
  localparam int         CAF_FLAG_N        = 3;
  localparam int         CAF_FLAG_Z        = 2;
  localparam int         CAF_FLAG_V        = 1;
  localparam int         CAF_FLAG_C        = 0;
  localparam logic [7:0] CAF_FLAGS_RESET   = 8'h80;

  // half-carry source bits per operand size
  localparam int         CAF_HALF_BYTE     = 3;
  localparam int         CAF_HALF_WORD     = 11;
  localparam int         CAF_HALF_LONG     = 27;

  // decimal adjust constants
  localparam logic [3:0] CAF_BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] CAF_BCD_BYTE_MAX  = 8'h99;
  localparam logic [7:0] CAF_BCD_LOW_FIX   = 8'h06;
  localparam logic [7:0] CAF_BCD_HIGH_FIX  = 8'h60;

  // step amounts
  localparam logic [31:0] CAF_STEP_ONE     = 32'h0000_0001;
  localparam logic [31:0] CAF_STEP_TWO     = 32'h0000_0002;
  localparam logic [31:0] CAF_STEP_FOUR    = 32'h0000_0004;

endpackage

// ===== testbench/caf_core_asserts.sv
`timescale 1ns/1ps
module caf_core_asserts
  import caf_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        exc_entry,
  input wire logic        mem_ack,
  input wire logic        ready_q,
  input wire logic        done_q,
  input wire logic        illegal_q,
  input wire logic [7:0]  flags_q,
  input wire logic        maskable_accept_q,
  input wire logic [15:0] fetch_addr_q,
  input wire logic        mem_req_q,
  input wire caf_size_t   mem_size_q,
  input wire logic [15:0] mem_addr_q
);
  // one domain, so one clock and one reset for all
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_irq_masked: assert property (maskable_accept_q |-> !$past(flags_q[7]))
    else $error("maskable accept while masked");
  a_exc_mask: assert property (exc_entry && clk_en |=> flags_q[7])
    else $error("exception entry left mask clear");
  a_fetch_even: assert property (fetch_addr_q[0] == 1'b0)
    else $error("odd fetch address");
  a_mem_even: assert property (mem_req_q && mem_size_q != CAF_BYTE |-> !mem_addr_q[0])
    else $error("odd wide memory address");
  a_mem_stall: assert property (mem_req_q && !mem_ack && clk_en |=> mem_req_q && $stable(mem_addr_q))
    else $error("access dropped before ack");
  a_mem_finish: assert property (mem_req_q && mem_ack && clk_en |=> done_q && !mem_req_q)
    else $error("access not finished after ack");
  a_busy_refuse: assert property (mem_req_q |-> !ready_q)
    else $error("ready during access");
  a_illegal_done: assert property (illegal_q |-> done_q)
    else $error("illegal without done");
  cover property (exc_entry);
  cover property (mem_req_q && mem_ack);
  cover property (illegal_q);
endmodule

bind caf_core caf_core_asserts caf_core_asserts_inst (.clk(clk), .rst_n(rst_n),
  .clk_en(clk_en), .exc_entry(exc_entry), .mem_ack(mem_ack), .ready_q(ready_q),
  .done_q(done_q), .illegal_q(illegal_q), .flags_q(flags_q),
  .maskable_accept_q(maskable_accept_q), .fetch_addr_q(fetch_addr_q),
  .mem_req_q(mem_req_q), .mem_size_q(mem_size_q), .mem_addr_q(mem_addr_q));

// ===== testbench/cpu_alu_and_condition_flags_bench.sv
`timescale 1ns/1ps
module cpu_alu_and_condition_flags_bench
  import caf_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, exc_entry = 1'b0;
  logic irq_pin = 1'b0, nmi_pin = 1'b0, mem_ack = 1'b0;
  logic [15:0] fetch_pc = 16'h0000;
  logic [31:0] mem_rdata = 32'h0000_0000;
  caf_req_t req = '0;
  logic ready_q, done_q, illegal_q, maskable_accept_q, nmi_accept_q;
  logic mem_req_q, mem_we_q;
  logic [31:0] result_q, mem_wdata_q, a, b;
  logic [7:0] flags_q;
  logic [15:0] fetch_addr_q, mem_addr_q;
  caf_size_t mem_size_q, s;
  caf_op_t o;
  caf_op_t ops[3] = '{CAF_ADD, CAF_SUB, CAF_COMPARE_OP};
  logic [3:0] x;
  logic [36:0] e;
  logic seen_illegal = 1'b0;
  int fail_count = 0, comparisons = 0;

  caf_core caf_core_inst (.clk, .rst_n, .clk_en(1'b1), .req_valid, .req,
    .exc_entry, .irq_pin, .nmi_pin, .fetch_pc, .mem_rdata, .mem_ack,
    .ready_q, .done_q, .illegal_q, .result_q, .flags_q, .maskable_accept_q,
    .nmi_accept_q, .fetch_addr_q, .mem_req_q, .mem_we_q, .mem_size_q,
    .mem_addr_q, .mem_wdata_q);

  // 200 MHz core clock
  initial forever #2.5 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] ex, gt);
    comparisons++;
    if (gt !== ex)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, ex, gt);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // called at a falling edge; returns where the answer is visible
  task automatic issue(input caf_op_t op, input caf_size_t sz,
    input logic [3:0] d, sr, input logic ui, input logic [31:0] im);
    req = '{op, sz, d, sr, ui, im};
    req_valid = 1'b1;
    @(negedge clk) req_valid = 1'b0;
    // illegal_q stands for one cycle only, so catch it while it stands
    seen_illegal = illegal_q;
    @(negedge clk);
  endtask

  // reference sum or difference with flags {res,h,n,z,v,c}
  function automatic logic [36:0] model(input logic sb, input caf_size_t sz,
    input logic [31:0] p, q);
    int w, hb;
    logic [32:0] r, hr;
    logic [31:0] m, hm, res;
    logic v;
    w = sz == CAF_BYTE ? 8 : sz == CAF_WORD ? 16 : 32;
    hb = w - 4;
    m = w == 32 ? 32'hffff_ffff : (32'h1 << w) - 32'h1;
    hm = (32'h1 << hb) - 32'h1;
    p &= m;
    q &= m;
    r = sb ? p - q : p + q;
    hr = sb ? (p & hm) - (q & hm) : (p & hm) + (q & hm);
    res = r[31:0] & m;
    v = (p[w-1] ^ res[w-1]) & (sb ? p[w-1] ^ q[w-1] : ~(p[w-1] ^ q[w-1]));
    return {res, hr[hb], res[w-1], res == 32'h0, v, r[w]};
  endfunction

  // main sequence
  initial
  begin
    void'($urandom(32'h0591));
    mem_rdata = $urandom;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("mask", 32'h1, {31'h0, flags_q[7]});
    issue(CAF_FLAGS_SET_INSN, CAF_BYTE, 4'h0, 4'h0, 1'b1, 32'h50);
    $display("test reset done");
    // first nine are the overflow and carry corners, then random
    for (int i = 0; i < 45; i++)
    begin
      s = caf_size_t'(i % 3);
      o = ops[(i / 3) % 3];
      a = i < 9 ? 32'h7fff_ffff : $urandom;
      b = i < 9 ? 32'h0000_0001 : $urandom;
      x = s == CAF_BYTE ? 4'h8 : 4'h0;
      issue(CAF_MOVE, CAF_LONG, 4'h0, 4'h0, 1'b1, a);
      issue(CAF_MOVE, CAF_LONG, 4'h1, 4'h0, 1'b1, b);
      issue(o, s, x, x + 4'h1, 1'b0, 32'h0);
      e = model(o != CAF_ADD, s, a, b);
      if (o != CAF_COMPARE_OP)
        chk("result", e[36:5], result_q);
      chk("flags", {27'h0, e[4:0]}, {27'h0, flags_q[5], flags_q[3:0]});
      chk("user", 32'h50, {24'h0, flags_q & 8'h50});
    end
    $display("test arith done");
    irq_pin = 1'b1;
    issue(CAF_FLAGS_MASK_INSN, CAF_BYTE, 4'h0, 4'h0, 1'b1, 32'h7f);
    repeat (4) @(negedge clk);
    chk("irq", 32'h1, {31'h0, maskable_accept_q});
    exc_entry = 1'b1;
    nmi_pin = 1'b1;
    @(negedge clk) exc_entry = 1'b0;
    repeat (4) @(negedge clk);
    chk("masked", 32'h0, {31'h0, maskable_accept_q});
    chk("nmi", 32'h1, {31'h0, nmi_accept_q});
    chk("mask", 32'h1, {31'h0, flags_q[7]});
    irq_pin = 1'b0;
    nmi_pin = 1'b0;
    $display("test interrupt done");
    // odd stack pointer, so the pre-decremented address is forced even
    issue(CAF_MOVE, CAF_LONG, 4'h7, 4'h0, 1'b1, 32'h0000_1001);
    issue(CAF_PUSH, CAF_WORD, 4'h0, 4'h0, 1'b0, 32'h0);
    chk("addr", 32'h0ffe, {16'h0, mem_addr_q});
    chk("we", 32'h1, {31'h0, mem_we_q});
    chk("wdata", {16'h0, a[15:0]}, mem_wdata_q);
    chk("size", {30'h0, CAF_WORD}, {30'h0, mem_size_q});
    chk("busy", 32'h0, {31'h0, ready_q});
    repeat ($urandom % 4) @(negedge clk);
    mem_ack = 1'b1;
    @(negedge clk) mem_ack = 1'b0;
    chk("done", 32'h1, {31'h0, done_q});
    issue(CAF_SUB, CAF_BYTE, 4'h8, 4'h0, 1'b1, 32'h5);
    chk("illegal", 32'h1, {31'h0, seen_illegal});
    chk("kept", {16'h0, a[15:0]}, result_q);
    $display("test push done");
    repeat (8)
    begin
      fetch_pc = $urandom;
      @(negedge clk);
      chk("fetch", {16'h0, fetch_pc & 16'hfffe}, {16'h0, fetch_addr_q});
    end
    $display("test fetch done");
    give_verdict;
  end

  // about 310 cycles expected; allow about thirteen times that
  initial
  begin
    #20000;
    fail_count++;
    give_verdict;
  end
endmodule
